/* csc_ctrl.sv */
`timescale 1ns/100ps
`default_nettype none
module csc_ctrl #(
  parameter int NUM_CH = 16
) (
  input wire logic clk_sys_i, // System clock
  input wire logic nrst_i, // Async reset, active low
  input wire logic [3:0] addr_i, // Register address
  input wire logic [7:0] wdata_i, // Write data
  input wire logic wr_i, // Write strobe
  input wire logic rd_i, // Read strobe
  output logic [7:0] rdata_o, // Read data, one cycle later
  input wire logic [3:0] timer_ovf_i, // Timer 0..3 overflow pulses
  input wire logic conv_done_i, // Analog conversion finished
  input wire logic [15:0] conv_value_i, // Analog conversion value
  output logic analog_en_o, // Analog front end powered
  output logic conv_start_o, // Start one conversion
  output logic [15:0] chan_sel_o, // Electrodes connected
  output logic [2:0] gain_o, // Gain code, 7 is 8x
  output logic [1:0] conv_len_o, // Conversion length code
  output logic irq_conv_o, // Completion interrupt level
  output logic irq_cmp_o, // Threshold interrupt level
  output logic wake_o // Wake from suspend pulse
);
  import csc_pkg::*;

  if (NUM_CH != 16) begin : g_chk
    $error("csc_ctrl serves exactly 16 channels");
  end

  function automatic logic [6:0] nsamp_m1(input logic [2:0] a);
    unique case (a)
      3'h0: nsamp_m1 = 7'h00;
      3'h1: nsamp_m1 = 7'h03;
      3'h2: nsamp_m1 = 7'h07;
      3'h3: nsamp_m1 = 7'h0F;
      3'h4: nsamp_m1 = 7'h1F;
      default: nsamp_m1 = 7'h3F;
    endcase
  endfunction

  function automatic logic [2:0] nshift(input logic [2:0] a);
    unique case (a)
      3'h0: nshift = 3'h0;
      3'h1: nshift = 3'h2;
      3'h2: nshift = 3'h3;
      3'h3: nshift = 3'h4;
      3'h4: nshift = 3'h5;
      default: nshift = 3'h6;
    endcase
  endfunction

  function automatic logic [15:0] lmask(input logic [1:0] c);
    unique case (c)
      CR_12: lmask = 16'hFFF0;
      CR_13: lmask = 16'hFFF8;
      CR_14: lmask = 16'hFFFC;
      default: lmask = 16'hFFFF;
    endcase
  endfunction

  // Next enabled channel after c, wrapping; c itself if none
  function automatic logic [3:0] nxt(input logic [15:0] m, input logic [3:0] c);
    logic [3:0] r;
    logic [3:0] k;
    r = c;
    for (int i = 16; i >= 1; i--) begin
      k = c + 4'(i);
      if (m[k]) r = k;
    end
    nxt = r;
  endfunction

  logic rst_s1;
  logic rst_n;
  always_ff @(posedge clk_sys_i or negedge nrst_i) begin
    if (!nrst_i) {rst_n, rst_s1} <= 2'b00;
    else {rst_n, rst_s1} <= {rst_s1, 1'b1};
  end

  logic en, woi, smen, mcen, ie_cpt, ie_cmp;
  logic done, eos, cmp, paused, wake;
  csc_mode_t mode;
  csc_state_t state;
  logic [2:0] acu, gain;
  logic [1:0] cr;
  logic [15:0] thr, result, scan;
  logic [3:0] mux_ch, ch;
  logic [6:0] cnt;
  logic [21:0] acc;
  logic [7:0] rdata;

  wire wr_ctrl = wr_i && addr_i == A_CTRL;
  wire busy_wr = wr_ctrl && wdata_i[B_BUSY] && en;
  wire idle = state == ST_IDLE;
  wire scanm = mode == CM_SCAN || mode == CM_CAS;
  wire [1:0] tsel = mode == CM_T0 ? 2'd0 : mode == CM_T1 ? 2'd1 : mode == CM_T2 ? 2'd2 : 2'd3;
  wire timed = mode inside {CM_T0, CM_T1, CM_T2, CM_T3};
  // Timer modes take their overflow pulse; every other mode waits for a busy write
  wire trig = timed ? timer_ovf_i[tsel] : busy_wr;
  wire start_req = idle && en && trig;
  wire samp_done = state == ST_WAIT && conv_done_i;
  wire last = cnt == nsamp_m1(acu);
  wire fin = samp_done && last;
  wire [15:0] sample = conv_value_i & lmask(cr);
  wire [21:0] sum = acc + {6'h00, sample};
  wire [21:0] quot = sum >> nshift(acu);
  wire [15:0] avg = quot[15:0];
  wire gt = avg > thr;
  wire [3:0] nx = nxt(scan, ch);
  wire eos_w = mcen || nx <= ch;
  wire eos_ev = fin && mode == CM_SCAN && !gt && eos_w;
  wire each_ev = fin && (mode == CM_CONT || mode == CM_CAS);
  wire next_wake = fin && (gt || woi && smen && (eos_ev || each_ev));
  wire [3:0] cur = scanm ? ch : mux_ch;
  wire [15:0] onehot = 16'h0001 << cur;

  // Each sample runs START then WAIT; the mode decides what follows the last one
  csc_state_t next_state;
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (start_req) next_state = ST_START;
      ST_START: next_state = ST_WAIT;
      ST_WAIT: begin
        if (samp_done && !last) next_state = ST_START;
        else if (fin) begin
          unique case (mode)
            CM_CONT: next_state = ST_START;
            CM_CAS: next_state = gt ? ST_IDLE : ST_START;
            CM_SCAN: next_state = (gt || eos_w) ? ST_IDLE : ST_START;
            default: next_state = ST_IDLE;
          endcase
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (!en) next_state = ST_IDLE;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      cnt <= 7'h00;
      acc <= 22'h000000;
      ch <= 4'h0;
      paused <= 1'b0;
      wake <= 1'b0;
    end else begin
      state <= next_state;
      wake <= next_wake;
      if (idle || fin) begin
        cnt <= 7'h00;
        acc <= 22'h000000;
      end else if (samp_done) begin
        cnt <= cnt + 7'h01;
        acc <= sum;
      end
      // Resume after a threshold stop, else restart at the lowest enabled channel
      if (start_req && scanm) ch <= paused ? nx : nxt(scan, 4'hF);
      else if (fin && scanm && !gt) ch <= nx;
      if (!en || start_req) paused <= 1'b0;
      else if (fin && scanm && gt) paused <= 1'b1;
    end
  end

  // Status flags; a hardware set wins over a software clear
  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      done <= 1'b0;
      eos <= 1'b0;
      cmp <= 1'b0;
      result <= 16'h0000;
    end else begin
      if (fin) begin
        result <= avg;
        cmp <= gt;
      end
      done <= fin || (done && !(wr_ctrl && !wdata_i[B_DONE]));
      eos <= eos_ev || (eos && !(wr_ctrl && !wdata_i[B_EOS]));
    end
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) begin
      en <= 1'b0;
      mode <= CM_SW;
      acu <= 3'h0;
      thr <= 16'h0000;
      scan <= 16'h0000;
      woi <= 1'b0;
      smen <= 1'b0;
      mcen <= 1'b0;
      cr <= RST_CR;
      gain <= RST_GAIN;
      ie_cpt <= 1'b0;
      ie_cmp <= 1'b0;
      mux_ch <= 4'h0;
    end else if (wr_i) begin
      unique case (addr_i)
        A_CTRL: en <= wdata_i[B_EN];
        A_CFG: begin
          mode <= csc_mode_t'(wdata_i[B_CM +: 3]);
          acu <= wdata_i[2:0];
        end
        A_THL: thr[7:0] <= wdata_i;
        A_THH: thr[15:8] <= wdata_i;
        A_SC0: scan[7:0] <= wdata_i;
        A_SC1: scan[15:8] <= wdata_i;
        A_MD1: begin
          woi <= wdata_i[B_WOI];
          smen <= wdata_i[B_SMEN];
        end
        A_MD2: begin
          cr <= wdata_i[1:0];
          mcen <= wdata_i[B_MCEN];
        end
        A_MD: gain <= wdata_i[2:0];
        A_IEN: begin
          ie_cpt <= wdata_i[B_ECPT];
          ie_cmp <= wdata_i[B_ECMP];
        end
        A_MUX: mux_ch <= wdata_i[3:0];
        default: ;
      endcase
    end
  end

  logic [7:0] rd_val;
  always_comb begin
    rd_val = 8'h00;
    unique case (addr_i)
      A_CTRL: rd_val = {en, eos, done, !idle, 3'h0, cmp};
      A_CFG: rd_val = {1'b0, mode, 1'b0, acu};
      A_THL: rd_val = thr[7:0];
      A_THH: rd_val = thr[15:8];
      A_DL: rd_val = result[7:0];
      A_DH: rd_val = result[15:8];
      A_SC0: rd_val = scan[7:0];
      A_SC1: rd_val = scan[15:8];
      A_MD1: rd_val = {6'h00, smen, woi};
      A_MD2: rd_val = {5'h00, mcen, cr};
      A_MD: rd_val = {5'h00, gain};
      A_IEN: rd_val = {2'h0, ie_cmp, 4'h0, ie_cpt};
      A_MUX: rd_val = {4'h0, mux_ch};
      default: rd_val = 8'h00;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n) begin
    if (!rst_n) rdata <= 8'h00;
    else rdata <= rd_i ? rd_val : 8'h00;
  end

  assign rdata_o = rdata;
  assign analog_en_o = en;
  // Enable gates the pulse so a clear racing a restart launches nothing
  assign conv_start_o = state == ST_START && en;
  assign chan_sel_o = mcen ? scan : onehot;
  assign gain_o = gain;
  assign conv_len_o = cr;
  assign irq_conv_o = ie_cpt && (done || eos);
  assign irq_cmp_o = ie_cmp && cmp;
  assign wake_o = wake;

  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n);

  off_no_conv_a: assert property (!en |-> !conv_start_o)
    else $error("conversion started while disabled");
  done_irq_a: assert property (fin && ie_cpt |=> irq_conv_o || !ie_cpt)
    else $error("completion interrupt missing after result");
  fin_done_a: assert property (fin |=> done)
    else $error("completion flag not set after last sample");
  cmp_flag_a: assert property (fin |=> cmp == $past(gt))
    else $error("threshold flag wrong after result");
  cont_wait_a: assert property (idle && !start_req |=> idle)
    else $error("conversion began without trigger");
  len_mask_a: assert property (fin && cr == CR_12 && acu == 3'h0 |=> result[3:0] == 4'h0)
    else $error("unconverted bits not zero");
  acc_pass_a: assert property (fin && acu == 3'h0 |=> result == $past(sample))
    else $error("single sample result not stored");
  acc_count_a: assert property (samp_done && acu == 3'h1 && cnt == 7'h00 |-> !fin)
    else $error("accumulation ended early");
  scan_halt_a: assert property (fin && gt && mode == CM_CAS |=> idle ##1 (idle || $past(busy_wr)))
    else $error("auto-scan continued after threshold");
  busy_read_a: assert property (conv_start_o |-> !idle ##1 !idle)
    else $error("busy low during conversion");
  wake_acc_a: assert property (wake_o |-> $past(fin))
    else $error("wake before accumulation finished");
  short_a: assert property (mcen |-> chan_sel_o == scan)
    else $error("channels not shorted");

  // Sequencing, interrupt, wake and result checks
  off_idle_a: assert property (!en |=> idle)
    else $error("unit active while disabled");
  start_one_a: assert property (conv_start_o |=> !conv_start_o)
    else $error("start pulse longer than one cycle");
  cont_run_a: assert property (fin && en && mode == CM_CONT |=> conv_start_o || !en)
    else $error("continuous mode did not restart");
  scan_stop_a: assert property (fin && gt && mode == CM_SCAN |=> idle)
    else $error("single scan continued after threshold");
  cmp_irq_a: assert property (fin && gt && ie_cmp |=> irq_cmp_o || !ie_cmp)
    else $error("threshold interrupt missing");
  thr_wake_a: assert property (fin && gt |=> wake_o)
    else $error("no wake on touch");
  eos_wake_a: assert property (eos_ev && woi && smen |=> wake_o)
    else $error("no wake at end of scan");
  wake_sel_a: assert property (fin && !gt && !(woi && smen) |=> !wake_o)
    else $error("wake without selected event");
  res_hold_a: assert property (!fin |=> result == $past(result))
    else $error("result changed without final sample");

  // Main scenarios
  touch_c: cover property (fin && gt);
  eos_c: cover property (eos_ev);
  wake_c: cover property (wake_o && !$past(gt));
  short_c: cover property (fin && mcen);
  cont_c: cover property (each_ev && mode == CM_CONT);
endmodule // csc_ctrl
`default_nettype wire

/* csc_pad_model.sv */
`timescale 1ns/100ps
`default_nettype none
module csc_pad_model (
  input wire logic clk_i, // System clock
  input wire logic start_i, // Start of one conversion
  input wire logic [15:0] val_i, // Value to return
  input wire logic [3:0] dly_i, // Extra wait cycles
  output logic done_o, // Conversion finished pulse
  output logic [15:0] val_o // Value, valid with done_o
);
  initial begin
    done_o = 1'b0;
    val_o = 16'h0000;
    forever begin
      @(posedge clk_i);
      if (start_i === 1'b1) begin
        repeat (dly_i + 1) @(posedge clk_i);
        done_o <= 1'b1;
        val_o <= val_i;
        @(posedge clk_i);
        done_o <= 1'b0;
        // Value reads inverted after the done pulse
        val_o <= ~val_i;
      end
    end
  end
endmodule // csc_pad_model
`default_nettype wire

/* csc_pkg.sv */
`default_nettype none
package csc_pkg;
  // Register offsets
  localparam logic [3:0] A_CTRL = 4'h0;
  localparam logic [3:0] A_CFG = 4'h1;
  localparam logic [3:0] A_THL = 4'h2;
  localparam logic [3:0] A_THH = 4'h3;
  localparam logic [3:0] A_DL = 4'h4;
  localparam logic [3:0] A_DH = 4'h5;
  localparam logic [3:0] A_SC0 = 4'h6;
  localparam logic [3:0] A_SC1 = 4'h7;
  localparam logic [3:0] A_MD1 = 4'h8;
  localparam logic [3:0] A_MD2 = 4'h9;
  localparam logic [3:0] A_MD = 4'hA;
  localparam logic [3:0] A_IEN = 4'hB;
  localparam logic [3:0] A_MUX = 4'hC;
  // Field positions
  localparam int B_EN = 7;
  localparam int B_EOS = 6;
  localparam int B_DONE = 5;
  localparam int B_BUSY = 4;
  localparam int B_CMP = 0;
  localparam int B_CM = 4;
  localparam int B_WOI = 0;
  localparam int B_SMEN = 1;
  localparam int B_MCEN = 2;
  localparam int B_ECPT = 0;
  localparam int B_ECMP = 5;
  // Reset values
  localparam logic [2:0] RST_GAIN = 3'h7;
  localparam logic [1:0] RST_CR = 2'h1;
  // Conversion length codes
  localparam logic [1:0] CR_12 = 2'h0;
  localparam logic [1:0] CR_13 = 2'h1;
  localparam logic [1:0] CR_14 = 2'h2;
  typedef enum logic [2:0] {
    CM_SW = 3'h0, CM_T0 = 3'h1, CM_T2 = 3'h2, CM_T1 = 3'h3,
    CM_T3 = 3'h4, CM_SCAN = 3'h5, CM_CONT = 3'h6, CM_CAS = 3'h7
  } csc_mode_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001, ST_START = 3'b010, ST_WAIT = 3'b100
  } csc_state_t;
endpackage
`default_nettype wire

/* tb.sv */
`timescale 1ns/100ps
`default_nettype none
module tb;
  import csc_pkg::*;
  logic clk_sys_i, nrst_i, wr_i, rd_i, conv_done_i, analog_en_o, conv_start_o;
  logic irq_conv_o, irq_cmp_o, wake_o, c;
  logic [3:0] addr_i, timer_ovf_i, dly, ch;
  logic [7:0] wdata_i, rdata_o, r, ien;
  logic [15:0] conv_value_i, chan_sel_o, val, thr, sel, e;
  logic [2:0] gain_o, acc, g;
  logic [1:0] conv_len_o, cr;
  int bad_count, cmp_count, starts, wakes, s0, w0;
  int tmr[4] = '{0, 2, 1, 3};
  csc_ctrl DUT (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .timer_ovf_i(timer_ovf_i),
    .conv_done_i(conv_done_i), .conv_value_i(conv_value_i), .analog_en_o(analog_en_o),
    .conv_start_o(conv_start_o), .chan_sel_o(chan_sel_o), .gain_o(gain_o),
    .conv_len_o(conv_len_o), .irq_conv_o(irq_conv_o), .irq_cmp_o(irq_cmp_o), .wake_o(wake_o));
  csc_pad_model pad (.clk_i(clk_sys_i), .start_i(conv_start_o), .val_i(val), .dly_i(dly),
    .done_o(conv_done_i), .val_o(conv_value_i));
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    if (conv_start_o === 1'b1) begin
      starts <= starts + 1;
      sel <= chan_sel_o;
    end
    if (wake_o === 1'b1) wakes <= wakes + 1;
  end
  task automatic chk(input string n, input logic [15:0] x, input logic [15:0] y);
    cmp_count++;
    if (y !== x) begin
      bad_count++;
      $display("CHECK FAILED %s exp %h got %h", n, x, y);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_sys_i);
    wr_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_sys_i);
    rd_i <= 1'b0;
    @(posedge clk_sys_i);
    d = rdata_o;
  endtask
  task automatic wait_idle;
    for (int k = 0; k < 1000; k++) begin
      rd(A_CTRL, r);
      if (r[B_BUSY] === 1'b0) return;
    end
    bad_count++;
    wrap_up();
  endtask
  task automatic wrap_up;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Converted bits sit at the top; the rest read zero
  function automatic logic [15:0] exp_res(input logic [15:0] v, input logic [1:0] l);
    exp_res = v & (16'hFFFF << ((l == 2'h3) ? 0 : 4 - l));
  endfunction
  initial begin
    nrst_i = 1'b0;
    {wr_i, rd_i, addr_i, wdata_i, timer_ovf_i, dly} = '0;
    val = 16'h1234;
    void'($urandom(46071));
    repeat (6) @(posedge clk_sys_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge clk_sys_i);
    chk("gain", 16'h0007, gain_o);
    chk("len", 16'h0001, conv_len_o);
    rd(A_MD, r);
    chk("md", 16'h0007, r);
    rd(A_MD2, r);
    chk("md2", 16'h0001, r);
    rd(4'hD, r);
    chk("unmapped", 16'h0000, r);
    wr(A_CTRL, 8'h10);
    repeat (10) @(posedge clk_sys_i);
    chk("off starts", 0, starts);
    $display("reset and shutdown test done");
    for (int i = 0; i < 8; i++) begin
      cr = 2'(i);
      acc = 3'($urandom_range(5, 0));
      g = 3'($urandom_range(7, 0));
      ch = 4'($urandom_range(15, 0));
      val = 16'($urandom);
      dly = 4'($urandom_range(7, 0));
      thr = (i == 0) ? exp_res(val, cr) : 16'($urandom);
      ien = i[0] ? 8'h21 : 8'h00;
      wr(A_CTRL, 8'h80);
      wr(A_CFG, {5'h00, acc});
      wr(A_MD2, {6'h00, cr});
      wr(A_MD, {5'h00, g});
      chk("gain", g, gain_o);
      wr(A_MUX, {4'h0, ch});
      wr(A_THL, thr[7:0]);
      wr(A_THH, thr[15:8]);
      wr(A_IEN, ien);
      wr(A_MD1, 8'h00);
      s0 = starts;
      w0 = wakes;
      wr(A_CTRL, 8'h90);
      rd(A_CTRL, r);
      chk("busy", 16'h0001, r[B_BUSY]);
      wait_idle();
      chk("samples", (acc == 0) ? 1 : 2 << acc, starts - s0);
      e = exp_res(val, cr);
      c = e > thr;
      rd(A_DL, r);
      chk("res lo", e[7:0], r);
      rd(A_DH, r);
      chk("res hi", e[15:8], r);
      rd(A_CTRL, r);
      chk("cmp flag", c, r[B_CMP]);
      chk("done flag", 16'h0001, r[B_DONE]);
      chk("irq conv", ien[0], irq_conv_o);
      chk("irq cmp", c & ien[5], irq_cmp_o);
      chk("wakes", c, wakes - w0);
      chk("chan", 16'h0001 << ch, sel);
      wr(A_CTRL, 8'h00);
      chk("irq clr", 16'h0000, irq_conv_o);
      chk("analog off", 16'h0000, analog_en_o);
    end
    $display("single conversion test done");
    for (int m = 0; m < 2; m++) begin
      wr(A_CTRL, 8'h80);
      wr(A_CFG, 8'h50);
      wr(A_MD2, {5'h00, m[0], 2'h1});
      wr(A_SC0, 8'h25);
      wr(A_SC1, 8'h00);
      wr(A_THL, 8'hFF);
      wr(A_THH, 8'hFF);
      wr(A_MD1, 8'h03);
      s0 = starts;
      w0 = wakes;
      wr(A_CTRL, 8'h90);
      wait_idle();
      chk("scan convs", m ? 1 : 3, starts - s0);
      rd(A_CTRL, r);
      chk("eos", 16'h0001, r[B_EOS]);
      chk("scan wake", 1, wakes - w0);
      if (m == 1) chk("short", 16'h0025, sel);
      wr(A_CTRL, 8'h00);
    end
    $display("scan test done");
    for (int k = 1; k < 5; k++) begin
      wr(A_CTRL, 8'h80);
      wr(A_CFG, {1'b0, 3'(k), 4'h0});
      s0 = starts;
      timer_ovf_i <= 4'h1 << (tmr[k - 1] ^ 1);
      @(posedge clk_sys_i);
      timer_ovf_i <= 4'h0;
      repeat (5) @(posedge clk_sys_i);
      chk("wrong timer", 0, starts - s0);
      timer_ovf_i <= 4'h1 << tmr[k - 1];
      @(posedge clk_sys_i);
      timer_ovf_i <= 4'h0;
      wait_idle();
      chk("timer", 1, starts - s0);
      wr(A_CTRL, 8'h00);
    end
    $display("timer trigger test done");
    val = 16'hF000;
    for (int k = 6; k < 8; k++) begin
      wr(A_CTRL, 8'h80);
      wr(A_CFG, {1'b0, 3'(k), 4'h0});
      wr(A_SC0, 8'h03);
      wr(A_THL, (k == 7) ? 8'h00 : 8'hFF);
      wr(A_THH, (k == 7) ? 8'h00 : 8'hFF);
      s0 = starts;
      w0 = wakes;
      repeat (20) @(posedge clk_sys_i);
      chk("cont idle", 0, starts - s0);
      wr(A_CTRL, 8'h90);
      repeat (100) @(posedge clk_sys_i);
      if (k == 6) chk("cont run", 1, starts - s0 > 3);
      else chk("scan halt", 1, starts - s0);
      if (k == 6) chk("cont wake", 1, wakes > w0 && wakes - w0 + 1 >= starts - s0);
      wr(A_CTRL, 8'h00);
      chk("analog off", 16'h0000, analog_en_o);
    end
    $display("continuous test done");
    wrap_up();
  end
endmodule // tb
`default_nettype wire
